//--- logic/rpos_top.sv
// remappable pin output and input select with apb registers
`timescale 1ns/1ps
`include "rpos_params.svh"
module rpos_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rpos_pkg::rpos_periph_type periph_out,
  output rpos_pkg::rpos_drive_type [31:0] pin_drive,
  input wire logic [31:0] pin_in,
  output logic [23:0] periph_in,
  output logic pin_map_lock
);
  import rpos_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // output routing; pin index = group*8 + letter a..h
  function automatic rpos_drive_type route(input logic [1:0] grp, input rpos_sel_type code,
                                           input rpos_periph_type p);
    rpos_drive_type d;
    d = '{oe: 1'b0, val: 1'b0};
    case (grp)
      2'h0: begin
        case (code)
          4'h1: d = '{oe: 1'b1, val: p.uart1_transmit};
          4'h2: d = '{oe: 1'b1, val: p.uart2_request_to_send};
          4'h3: d = '{oe: 1'b1, val: p.spi1_slave_select};
          4'h5: d = '{oe: 1'b1, val: p.compare_out[0]};
          4'h7: d = '{oe: 1'b1, val: p.comparator_out[1]};
          default: d = '{oe: 1'b0, val: 1'b0};
        endcase
      end
      2'h1: begin
        case (code)
          4'h3: d = '{oe: 1'b1, val: p.spi1_serial_out};
          4'h4: d = '{oe: 1'b1, val: p.spi2_serial_out};
          4'h5: d = '{oe: 1'b1, val: p.compare_out[1]};
          4'h7: d = '{oe: 1'b1, val: p.comparator_out[2]};
          default: d = '{oe: 1'b0, val: 1'b0};
        endcase
      end
      2'h2: begin
        case (code)
          4'h3: d = '{oe: 1'b1, val: p.spi1_serial_out};
          4'h4: d = '{oe: 1'b1, val: p.spi2_serial_out};
          4'h5: d = '{oe: 1'b1, val: p.compare_out[3]};
          4'h6: d = '{oe: 1'b1, val: p.compare_out[4]};
          4'h7: d = '{oe: 1'b1, val: p.reference_clock_out};
          default: d = '{oe: 1'b0, val: 1'b0};
        endcase
      end
      default: begin
        case (code)
          4'h1: d = '{oe: 1'b1, val: p.uart1_request_to_send};
          4'h2: d = '{oe: 1'b1, val: p.uart2_transmit};
          4'h4: d = '{oe: 1'b1, val: p.spi2_slave_select};
          4'h5: d = '{oe: 1'b1, val: p.compare_out[2]};
          4'h7: d = '{oe: 1'b1, val: p.comparator_out[0]};
          default: d = '{oe: 1'b0, val: 1'b0};
        endcase
      end
    endcase
    return d;
  endfunction : route

  ////////////////////////////////////////////////////////////////////////
  // registers
  rpos_sel_type out_sel_ff [`RPOS_NUM_OUT];
  rpos_sel_type nxt_out_sel [`RPOS_NUM_OUT];
  rpos_sel_type in_sel_ff [`RPOS_NUM_IN];
  rpos_sel_type nxt_in_sel [`RPOS_NUM_IN];
  logic lock_ff, nxt_lock;
  logic oneway_ff, nxt_oneway;
  logic [31:0] prdata_ff, nxt_prdata;
  rpos_drive_type [31:0] drive_ff, nxt_drive;
  logic [23:0] pin_in_sel_ff, nxt_pin_in_sel;

  logic wr_en, rd_en;
  logic out_hit, in_hit, cfg_hit;
  logic [4:0] out_idx, in_idx;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  // word hit inside a selector window; the low two address bits are ignored
  function automatic logic win_hit(input logic [11:0] addr, input logic [11:0] base, input int count);
    logic hit;
    hit = (addr[11:8] == base[11:8]) && (int'(addr[7:2]) < count);
    return hit;
  endfunction : win_hit

  // selectors are four bits wide, the rest of the word reads zero
  function automatic logic [31:0] sel_word(input rpos_sel_type sel);
    logic [31:0] w;
    w = {28'h0, sel};
    return w;
  endfunction : sel_word

  assign wr_en = psel && penable && pwrite;
  // read data fetched in setup, so it stands through the access phase
  assign rd_en = psel && !penable && !pwrite;
  assign out_hit = win_hit(paddr, `RPOS_OUT_BASE, `RPOS_NUM_OUT);
  assign in_hit = win_hit(paddr, `RPOS_IN_BASE, `RPOS_NUM_IN);
  assign cfg_hit = (paddr == `RPOS_CFG_ADDR);
  assign out_idx = paddr[6:2];
  assign in_idx = paddr[6:2];

  // zero wait states; locked and unmapped writes end quietly
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_ff;
  assign pin_drive = drive_ff;
  assign periph_in = pin_in_sel_ff;
  assign pin_map_lock = lock_ff;

  ////////////////////////////////////////////////////////////////////////
  // selector bank
  always_comb begin
    nxt_out_sel = out_sel_ff;
    nxt_in_sel = in_sel_ff;
    // a locked write still completes on the bus, it only leaves the bank alone
    if (wr_en && !lock_ff) begin
      if (out_hit) begin
        nxt_out_sel[out_idx] = pwdata[3:0];
      end
      if (in_hit) begin
        nxt_in_sel[in_idx] = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `RPOS_NUM_OUT; i++) begin
        out_sel_ff[i] <= `RPOS_SEL_RESET;
      end
      for (int j = 0; j < `RPOS_NUM_IN; j++) begin
        in_sel_ff[j] <= `RPOS_SEL_RESET;
      end
    end else begin
      out_sel_ff <= nxt_out_sel;
      in_sel_ff <= nxt_in_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration control
  always_comb begin
    nxt_lock = lock_ff;
    nxt_oneway = oneway_ff;
    if (wr_en && cfg_hit) begin
      // once set with one-write-session on, only reset clears the lock
      if (!(lock_ff && oneway_ff)) begin
        nxt_lock = pwdata[`RPOS_LOCK_BIT];
      end
      // session mode frozen while locked, else the lock could be reopened
      if (!lock_ff) begin
        nxt_oneway = pwdata[`RPOS_ONEWAY_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_ff <= `RPOS_LOCK_RESET;
      oneway_ff <= `RPOS_CFG_ONEWAY_RESET;
    end else begin
      lock_ff <= nxt_lock;
      oneway_ff <= nxt_oneway;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_en) begin
      nxt_prdata = 32'h0;
      if (out_hit) begin
        nxt_prdata = sel_word(out_sel_ff[out_idx]);
      end else if (in_hit) begin
        nxt_prdata = sel_word(in_sel_ff[in_idx]);
      end else if (cfg_hit) begin
        nxt_prdata[`RPOS_LOCK_BIT] = lock_ff;
        nxt_prdata[`RPOS_ONEWAY_BIT] = oneway_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive; registered, so a pin follows its selector one cycle late
  always_comb begin
    for (int i = 0; i < `RPOS_NUM_OUT; i++) begin
      nxt_drive[i] = route(2'(i / 8), out_sel_ff[i], periph_out);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral inputs; input j looks at the pins of group j / 6
  always_comb begin
    for (int j = 0; j < `RPOS_NUM_IN; j++) begin
      // codes 8..15 are reserved: input reads zero
      nxt_pin_in_sel[j] = in_sel_ff[j][3] ? 1'b0
                          : pin_in[{2'(j / 6), in_sel_ff[j][2:0]}];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_in_sel_ff <= 24'h0;
    end else begin
      pin_in_sel_ff <= nxt_pin_in_sel;
    end
  end
endmodule : rpos_top

//--- logic/rpos_params.svh
// constants for the remappable pin output select block
// Summary of operation
// - each output selector holds a 4-bit rw field, reset zero, upper bits read zero.
// - each input selector holds a 4-bit rw field naming its source pin, reset zero.
// - selector fields take new values only while the pin-map lock bit 13 is zero.
// - group one codes route uart1 tx, uart2 rts, spi1 ss, compare 1, comparator 2.
// - group two codes route spi1 out, spi2 out, compare 2, comparator 3.
// - group three codes route spi1 out, spi2 out, compare 4, compare 5, reference clock.
// - group four codes route uart1 rts, uart2 tx, spi2 ss, compare 3, comparator 1.
// - locked selector writes complete without bus error but change nothing.
// - with one-write-session set, the lock cannot be cleared once set until reset.
// - input selectors are owned per peripheral input; output selectors per pin.
`ifndef RPOS_PARAMS_SVH
`define RPOS_PARAMS_SVH
`define RPOS_NUM_OUT 32
`define RPOS_NUM_IN 24
`define RPOS_OUT_BASE 12'h000
`define RPOS_IN_BASE 12'h100
`define RPOS_CFG_ADDR 12'h200
`define RPOS_LOCK_BIT 13
`define RPOS_ONEWAY_BIT 29
`define RPOS_SEL_RESET 4'h0
`define RPOS_LOCK_RESET 1'b0
`define RPOS_CFG_ONEWAY_RESET 1'b1
`endif

//--- logic/rpos_pkg.sv
// types for the remappable pin output select block
package rpos_pkg;
  typedef logic [3:0] rpos_sel_type;
  typedef struct packed {
    logic uart1_transmit;
    logic uart1_request_to_send;
    logic uart2_transmit;
    logic uart2_request_to_send;
    logic spi1_slave_select;
    logic spi2_slave_select;
    logic spi1_serial_out;
    logic spi2_serial_out;
    logic [4:0] compare_out;
    logic [2:0] comparator_out;
    logic reference_clock_out;
  } rpos_periph_type;
  typedef struct packed {
    logic oe;
    logic val;
  } rpos_drive_type;
endpackage : rpos_pkg

//--- verif/rpos_checker.sv
// port checker for the pin select block
`timescale 1ns/1ps
module rpos_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_map_lock,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [31:0] pin_in,
  input wire logic [23:0] periph_in,
  input wire rpos_pkg::rpos_periph_type periph_out,
  input wire rpos_pkg::rpos_drive_type [31:0] pin_drive
);
  import rpos_pkg::*;
  logic [3:0] sel_ff, isel_ff;
  logic oneway_ff;
  wire wr_ok = psel && penable && pwrite && !pin_map_lock;
  wire cfg_wr = psel && penable && pwrite && paddr == 12'h200;
  wire pick = pin_in[isel_ff[2:0]];
  // shadows of pin 0 output select and input 0 select
  always_ff @(posedge clk) begin
    if (sys_rst) {sel_ff, isel_ff} <= 8'h00;
    else if (wr_ok && paddr == 12'h000) sel_ff <= pwdata[3:0];
    else if (wr_ok && paddr == 12'h100) isel_ff <= pwdata[3:0];
  end
  // session mode as software last set it while unlocked
  always_ff @(posedge clk) begin
    if (sys_rst) oneway_ff <= 1'b1;
    else if (cfg_wr && !pin_map_lock) oneway_ff <= pwdata[29];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  bus_ok_a: assert property (pready && !pslverr) else $error("bus");
  upper_zero_a: assert property (psel && penable && !pwrite && paddr < 12'h200 |-> prdata[31:4] == 28'h0)
    else $error("upper");
  read_back_a: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=> prdata == {28'h0, sel_ff})
    else $error("readback");
  lock_set_a: assert property (cfg_wr && pwdata[13] |=> pin_map_lock) else $error("lock set");
  lock_hold_a: assert property (pin_map_lock && !cfg_wr |=> pin_map_lock) else $error("lock lost");
  lock_sticky_a: assert property (pin_map_lock && oneway_ff |=> pin_map_lock) else $error("lock reopened");
  no_conn_a: assert property (sel_ff == 4'h0 |=> !pin_drive[0].oe) else $error("no connect");
  pin_route_a: assert property (sel_ff == 4'h5 |=> pin_drive[0] == {1'b1, $past(periph_out.compare_out[0])})
    else $error("route");
  in_route_a: assert property (!isel_ff[3] |=> periph_in[0] == $past(pick)) else $error("input");
  in_reserved_a: assert property (isel_ff[3] |=> !periph_in[0]) else $error("reserved input");
  cover property (pin_drive[0].oe);
  cover property (pin_map_lock && cfg_wr);
  cover property (isel_ff[3]);
  cover property (pin_map_lock && oneway_ff && cfg_wr && !pwdata[13]);
endmodule : rpos_checker
////////////////////////////////////////
bind rpos_top rpos_checker rpos_checker_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .pready, .pslverr,
  .pin_map_lock, .paddr, .pwdata, .prdata, .pin_in, .periph_in, .periph_out, .pin_drive);

//--- verif/rpos_periph_model.sv
// stand-in for peripheral outputs and pin levels
`timescale 1ns/1ps
module rpos_periph_model (
  input wire logic clk,
  output rpos_pkg::rpos_periph_type periph_out,
  output logic [31:0] pin_in
);
  import rpos_pkg::*;
  logic [31:0] cnt_ff = 32'h0;
  // odd step keeps bits moving so a stale pick shows
  always @(posedge clk) cnt_ff <= cnt_ff + 32'h9e37_79b1;
  assign periph_out = rpos_periph_type'(cnt_ff[16:0]);
  assign pin_in = cnt_ff ^ {cnt_ff[15:0], cnt_ff[31:16]};
endmodule : rpos_periph_model

//--- verif/rpos_top_tb.sv
// self-checking bench for the pin select block
`timescale 1ns/1ps
module rpos_top_tb;
  import rpos_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, pin_map_lock;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pin_in;
  logic [23:0] periph_in;
  rpos_periph_type periph_out;
  rpos_drive_type [31:0] pin_drive;
  int n_fail = 0, n_checks = 0;
  rpos_top rpos_top_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .periph_out, .pin_drive, .pin_in, .periph_in, .pin_map_lock);
  rpos_periph_model rpos_periph_model_inst (.clk, .periph_out, .pin_in);
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("rd", e, rd);
  endtask : rchk
  task automatic t_regs;
    rchk(12'h07c, 32'h0);
    rchk(12'h15c, 32'h0);
    rchk(12'h200, 32'h2000_0000);
    rchk(12'h300, 32'h0);
    xfer(1'b1, 12'h000, 32'hffff_ffff);
    rchk(12'h000, 32'h0000_000f);
    $display("register test done");
  endtask : t_regs
  task automatic t_route;
    // codes that drive a pin, one mask per output group
    logic [15:0] m[4] = '{16'h00ae, 16'h00b8, 16'h00f8, 16'h00b6};
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 16; c++) begin
        xfer(1'b1, 12'(g * 32), 32'(c));
        @(posedge clk);
        #1 chk("oe", 32'(m[g][c]), 32'(pin_drive[g * 8].oe));
      end
    end
    $display("route test done");
  endtask : t_route
  task automatic t_input(input int j, input logic [3:0] c);
    logic [31:0] v;
    xfer(1'b1, 12'(256 + 4 * j), 32'(c));
    @(posedge clk);
    v = pin_in;
    #1 chk("in", c[3] ? 32'h0 : 32'(v[j / 6 * 8 + c[2:0]]), 32'(periph_in[j]));
    $display("input test done");
  endtask : t_input
  task automatic t_lock;
    xfer(1'b1, 12'h200, 32'h2000_2000);
    xfer(1'b1, 12'h000, 32'h5);
    rchk(12'h000, 32'h0000_000f);
    xfer(1'b1, 12'h100, 32'h4);
    rchk(12'h100, 32'h0000_0009);
    xfer(1'b1, 12'h200, 32'h0);
    rchk(12'h200, 32'h2000_2000);
    $display("lock test done");
  endtask : t_lock
  task automatic t_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(12'h200, 32'h2000_0000);
    xfer(1'b1, 12'h004, 32'h7);
    rchk(12'h004, 32'h0000_0007);
    rchk(12'h000, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_route();
    t_input(0, 4'h3);
    t_input(23, 4'h7);
    t_input(0, 4'h9);
    t_lock();
    t_reset();
    report_and_stop();
  end
  // tests need under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule : rpos_top_tb
